// ===== dmacs_pkg.sv
package dmacs_pkg;

  // ---------------------------------------------------------------
  // Register map (word index per channel, channel select above it)
  // ---------------------------------------------------------------
  localparam logic [1:0] REG_CONTROL   = 2'h0;
  localparam logic [1:0] REG_STATUS    = 2'h1;
  localparam logic [1:0] REG_NVECTOR   = 2'h2;
  localparam logic [1:0] REG_EVECTOR   = 2'h3;
  localparam logic [2:0] REG_CFG       = 3'h4;
  localparam logic [2:0] REG_ERRCODE   = 3'h5;
  localparam logic [2:0] REG_MCOUNT    = 3'h6;
  localparam logic [2:0] REG_BCOUNT    = 3'h7;

  // ---------------------------------------------------------------
  // Control bit positions
  // ---------------------------------------------------------------
  localparam int CTL_START = 7;
  localparam int CTL_CONT  = 6;
  localparam int CTL_HALT  = 5;
  localparam int CTL_ABORT = 4;
  localparam int CTL_IE    = 3;

  // ---------------------------------------------------------------
  // Status bit positions
  // ---------------------------------------------------------------
  localparam int STS_COC = 7;
  localparam int STS_BLK = 6;
  localparam int STS_NDT = 5;
  localparam int STS_ERR = 4;
  localparam int STS_ACT = 3;
  localparam int STS_PCT = 1;
  localparam int STS_PCS = 0;

  // ---------------------------------------------------------------
  // Configuration fields: chain mode [1:0], pcl interrupt [2]
  // ---------------------------------------------------------------
  localparam logic [1:0] CHAIN_NONE     = 2'h0;
  localparam logic [1:0] CHAIN_RESERVED = 2'h1;
  localparam logic [1:0] CHAIN_ARRAY    = 2'h2;
  localparam logic [1:0] CHAIN_LINKED   = 2'h3;
  localparam int         CFG_PCL_IRQ    = 2;

  // ---------------------------------------------------------------
  // Error codes and reset values
  // ---------------------------------------------------------------
  localparam logic [4:0] ERR_NONE   = 5'h00;
  localparam logic [4:0] ERR_CONFIG = 5'h01;
  localparam logic [4:0] ERR_TIMING = 5'h02;
  localparam logic [4:0] ERR_BUS    = 5'h09;
  localparam logic [4:0] ERR_COUNT  = 5'h0d;
  localparam logic [4:0] ERR_ABORT  = 5'h11;
  localparam logic [7:0] VEC_RESET  = 8'h0f;
  localparam int         PCL_LOW_CYC = 2;

endpackage

// ===== dmacs_ctl.sv
`timescale 1ns/1ps
// Summary of operation
// - start bit activates channel, self-clears, sets active, drops pending requests.
// - start with reserved option gives configuration error, no operation.
// - zero memory count, or zero base count in array chaining, gives count error.
// - start while active/complete/block/termination/error set gives timing error.
// - continue in a chaining mode gives configuration error.
// - continue allowed only with start or while active with block-complete clear, else timing error.
// - count exhausted with continue reloads base, sets block-complete, clears continue.
// - halt keeps recognising requests but no transfers until cleared.
// - software abort stops channel, sets error and complete, clears active.
// - abort bit clears with error flag and always reads zero.
// - count decrements per operand; final block end pulses done, sets complete.
// - in continue mode done pulses at every block end.
// - bus error ends channel, sets error, complete and error code.
// - status write-one-to-clear; active and level bits ignore writes.
// - level bit mirrors peripheral control line.
// - transition flag sets on falling edge held low two cycles.
// - done input while acknowledged sets normal-termination flag.
// - interrupt request is enable and any of complete, block, termination, error, or configured transition flag.
// - acknowledge supplies vector from highest priority requesting channel.
// - error vector if error flag set, else normal vector, with acknowledge.
// - reset loads vector registers with uninitialised value.
module dmacs_ctl #(
  parameter int NCH = 4,
  parameter int CW  = 16
) (
  input  wire logic             clk_i,
  input  wire logic             reset_n_i,
  input  wire logic [4:0]       addr_i,
  input  wire logic [7:0]       wdata_i,
  input  wire logic             wr_i,
  input  wire logic             rd_i,
  output logic [7:0]            rdata_o,
  input  wire logic [NCH-1:0]   req_i,
  input  wire logic [NCH-1:0]   operand_done_i,
  input  wire logic [NCH-1:0]   bus_error_i,
  input  wire logic [NCH-1:0]   ack_i,
  input  wire logic [NCH-1:0]   done_i,
  input  wire logic [NCH-1:0]   peripheral_control_line_i,
  input  wire logic             interrupt_acknowledge_input_i,
  output logic [NCH-1:0]        pending_req_o,
  output logic [NCH-1:0]        xfer_enable_o,
  output logic [NCH-1:0]        done_o,
  output logic [NCH-1:0]        irq_o,
  output logic                  irq_any_o,
  output logic [7:0]            vector_o,
  output logic                  transfer_acknowledge_o
);

  initial begin
    if (NCH != 4 || CW < 2 || CW > 16) begin
      $error("dmacs_ctl: unsupported parameters");
    end
  end

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [4:0] a, input int ch, input logic [2:0] r);
    hit = (a[4:3] == ch[1:0]) && (a[2:0] == r);
  endfunction

  // ---------------------------------------------------------------
  // Per-channel state
  // ---------------------------------------------------------------
  logic [NCH-1:0] cont_ff, halt_ff, ie_ff, act_ff, coc_ff, blk_ff, ndt_ff, err_ff, pct_ff;
  logic [NCH-1:0] pend_ff, done_ff, irq_ff, pcl_d1_ff, pcl_d2_ff;
  logic [2:0]     cfg_ff [NCH];
  logic [4:0]     ecode_ff [NCH];
  logic [7:0]     nvec_ff [NCH];
  logic [7:0]     evec_ff [NCH];
  logic [CW-1:0]  mcnt_ff [NCH];
  logic [CW-1:0]  bcnt_ff [NCH];
  logic [NCH-1:0] irq_c;

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : gch
      logic wr_ctl, wr_sts, start, cont_req, any_busy, chain;
      logic cfg_bad, cnt_bad, cont_bad, cont_late, end_blk, last;
      assign wr_ctl   = wr_i && hit(addr_i, g, {1'b0, dmacs_pkg::REG_CONTROL});
      assign wr_sts   = wr_i && hit(addr_i, g, {1'b0, dmacs_pkg::REG_STATUS});
      assign start    = wr_ctl && wdata_i[dmacs_pkg::CTL_START];
      assign cont_req = wr_ctl && wdata_i[dmacs_pkg::CTL_CONT] && !cont_ff[g];
      assign chain    = cfg_ff[g][1];
      assign any_busy = act_ff[g] | coc_ff[g] | blk_ff[g] | ndt_ff[g] | err_ff[g];
      assign cfg_bad  = (cfg_ff[g][1:0] == dmacs_pkg::CHAIN_RESERVED)
                        || (wdata_i[dmacs_pkg::CTL_CONT] && chain);
      assign cnt_bad  = (mcnt_ff[g] == '0)
                        || (cfg_ff[g][1:0] == dmacs_pkg::CHAIN_ARRAY && bcnt_ff[g] == '0);
      assign cont_bad = cont_req && chain;
      assign cont_late = cont_req && !start && (!act_ff[g] || blk_ff[g]);
      assign last     = mcnt_ff[g] == CW'(1);
      assign end_blk  = act_ff[g] && operand_done_i[g] && !halt_ff[g] && last;

      // Channel operation sequencing and error detection
      always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          act_ff[g]   <= 1'b0;
          coc_ff[g]   <= 1'b0;
          blk_ff[g]   <= 1'b0;
          ndt_ff[g]   <= 1'b0;
          err_ff[g]   <= 1'b0;
          cont_ff[g]  <= 1'b0;
          ecode_ff[g] <= dmacs_pkg::ERR_NONE;
          mcnt_ff[g]  <= '0;
          done_ff[g]  <= 1'b0;
        end else begin
          done_ff[g] <= 1'b0;
          // Write-one-to-clear first; hardware sets below win
          if (wr_sts) begin
            coc_ff[g] <= coc_ff[g] & ~wdata_i[dmacs_pkg::STS_COC];
            blk_ff[g] <= blk_ff[g] & ~wdata_i[dmacs_pkg::STS_BLK];
            ndt_ff[g] <= ndt_ff[g] & ~wdata_i[dmacs_pkg::STS_NDT];
            err_ff[g] <= err_ff[g] & ~wdata_i[dmacs_pkg::STS_ERR];
          end
          if (wr_i && hit(addr_i, g, dmacs_pkg::REG_MCOUNT) && !act_ff[g]) begin
            mcnt_ff[g][7:0] <= wdata_i;
          end
          if (wr_ctl && !start && !cont_bad && !cont_late && wdata_i[dmacs_pkg::CTL_CONT]) begin
            cont_ff[g] <= 1'b1;
          end
          if (start && any_busy) begin
            err_ff[g]   <= 1'b1;
            coc_ff[g]   <= 1'b1;
            ecode_ff[g] <= dmacs_pkg::ERR_TIMING;
          end else if (start && cfg_bad) begin
            err_ff[g]   <= 1'b1;
            coc_ff[g]   <= 1'b1;
            ecode_ff[g] <= dmacs_pkg::ERR_CONFIG;
          end else if (start && cnt_bad) begin
            err_ff[g]   <= 1'b1;
            coc_ff[g]   <= 1'b1;
            ecode_ff[g] <= dmacs_pkg::ERR_COUNT;
          end else if (start) begin
            act_ff[g]  <= 1'b1;
            cont_ff[g] <= wdata_i[dmacs_pkg::CTL_CONT];
          end else if (cont_bad || cont_late) begin
            err_ff[g]   <= 1'b1;
            coc_ff[g]   <= 1'b1;
            act_ff[g]   <= 1'b0;
            ecode_ff[g] <= cont_bad ? dmacs_pkg::ERR_CONFIG : dmacs_pkg::ERR_TIMING;
          end else if (act_ff[g] && wr_ctl && wdata_i[dmacs_pkg::CTL_ABORT]) begin
            act_ff[g]   <= 1'b0;
            err_ff[g]   <= 1'b1;
            coc_ff[g]   <= 1'b1;
            ecode_ff[g] <= dmacs_pkg::ERR_ABORT;
          end else if (act_ff[g] && bus_error_i[g]) begin
            act_ff[g]   <= 1'b0;
            err_ff[g]   <= 1'b1;
            coc_ff[g]   <= 1'b1;
            ecode_ff[g] <= dmacs_pkg::ERR_BUS;
          end else if (act_ff[g] && ack_i[g] && done_i[g]) begin
            act_ff[g] <= 1'b0;
            ndt_ff[g] <= 1'b1;
            coc_ff[g] <= 1'b1;
          end else if (end_blk && cont_ff[g]) begin
            mcnt_ff[g] <= bcnt_ff[g];
            blk_ff[g]  <= 1'b1;
            cont_ff[g] <= 1'b0;
            done_ff[g] <= 1'b1;
            if (bcnt_ff[g] == '0) begin
              act_ff[g]   <= 1'b0;
              err_ff[g]   <= 1'b1;
              coc_ff[g]   <= 1'b1;
              ecode_ff[g] <= dmacs_pkg::ERR_COUNT;
            end
          end else if (end_blk) begin
            mcnt_ff[g] <= '0;
            act_ff[g]  <= 1'b0;
            coc_ff[g]  <= 1'b1;
            done_ff[g] <= 1'b1;
          end else if (act_ff[g] && operand_done_i[g] && !halt_ff[g]) begin
            mcnt_ff[g] <= mcnt_ff[g] - CW'(1);
          end
          if (!act_ff[g] && !start) begin
            cont_ff[g] <= cont_ff[g] & ~(wr_ctl & ~wdata_i[dmacs_pkg::CTL_CONT]);
          end
        end
      end

      // Control and configuration storage
      always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          halt_ff[g] <= 1'b0;
          ie_ff[g]   <= 1'b0;
          cfg_ff[g]  <= 3'h0;
          bcnt_ff[g] <= '0;
          nvec_ff[g] <= dmacs_pkg::VEC_RESET;
          evec_ff[g] <= dmacs_pkg::VEC_RESET;
        end else begin
          if (wr_ctl) begin
            halt_ff[g] <= wdata_i[dmacs_pkg::CTL_HALT];
            ie_ff[g]   <= wdata_i[dmacs_pkg::CTL_IE];
          end
          if (wr_i && hit(addr_i, g, dmacs_pkg::REG_CFG)) cfg_ff[g] <= wdata_i[2:0];
          if (wr_i && hit(addr_i, g, dmacs_pkg::REG_BCOUNT)) bcnt_ff[g][7:0] <= wdata_i;
          if (wr_i && hit(addr_i, g, {1'b0, dmacs_pkg::REG_NVECTOR})) nvec_ff[g] <= wdata_i;
          if (wr_i && hit(addr_i, g, {1'b0, dmacs_pkg::REG_EVECTOR})) evec_ff[g] <= wdata_i;
        end
      end

      // Request latch: cleared at start, held through halt
      always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          pend_ff[g] <= 1'b0;
        end else if (start) begin
          pend_ff[g] <= 1'b0;
        end else if (req_i[g] && act_ff[g]) begin
          pend_ff[g] <= 1'b1;
        end else if (operand_done_i[g] && !halt_ff[g]) begin
          pend_ff[g] <= 1'b0;
        end
      end

      // Peripheral line sampling and transition flag
      always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          pcl_d1_ff[g] <= 1'b1;
          pcl_d2_ff[g] <= 1'b1;
          pct_ff[g]    <= 1'b0;
        end else begin
          pcl_d1_ff[g] <= peripheral_control_line_i[g];
          pcl_d2_ff[g] <= pcl_d1_ff[g];
          // High, then low on two successive samples
          if (!peripheral_control_line_i[g] && !pcl_d1_ff[g] && pcl_d2_ff[g]) begin
            pct_ff[g] <= 1'b1;
          end else if (wr_sts && wdata_i[dmacs_pkg::STS_PCT]) begin
            pct_ff[g] <= 1'b0;
          end
        end
      end

      assign irq_c[g] = ie_ff[g] && (coc_ff[g] || blk_ff[g] || err_ff[g] || ndt_ff[g]
                        || (pct_ff[g] && cfg_ff[g][dmacs_pkg::CFG_PCL_IRQ]));
    end
  endgenerate

  // ---------------------------------------------------------------
  // Outputs and vector supply
  // ---------------------------------------------------------------
  logic [7:0] vsel;
  always_comb begin
    vsel = 8'h00;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (irq_c[i]) vsel = err_ff[i] ? evec_ff[i] : nvec_ff[i];
    end
  end

  // Registered outputs, lowest channel number has priority
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_ff                 <= '0;
      irq_any_o              <= 1'b0;
      vector_o               <= 8'h00;
      transfer_acknowledge_o <= 1'b0;
      pending_req_o          <= '0;
      xfer_enable_o          <= '0;
      done_o                 <= '0;
    end else begin
      irq_ff                 <= irq_c;
      irq_any_o              <= |irq_c;
      transfer_acknowledge_o <= interrupt_acknowledge_input_i && (|irq_c);
      vector_o               <= (interrupt_acknowledge_input_i && (|irq_c)) ? vsel : 8'h00;
      pending_req_o          <= pend_ff;
      xfer_enable_o          <= act_ff & ~halt_ff & ~bus_error_i;
      done_o                 <= done_ff;
    end
  end
  assign irq_o = irq_ff;

  // ---------------------------------------------------------------
  // Register read, data one cycle after strobe
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i[2:0])
        3'h0:    rdata_o <= {1'b0, cont_ff[addr_i[4:3]], halt_ff[addr_i[4:3]], 1'b0,
                             ie_ff[addr_i[4:3]], 3'h0};
        3'h1:    rdata_o <= {coc_ff[addr_i[4:3]], blk_ff[addr_i[4:3]], ndt_ff[addr_i[4:3]],
                             err_ff[addr_i[4:3]], act_ff[addr_i[4:3]], 1'b0,
                             pct_ff[addr_i[4:3]], pcl_d1_ff[addr_i[4:3]]};
        3'h2:    rdata_o <= nvec_ff[addr_i[4:3]];
        3'h3:    rdata_o <= evec_ff[addr_i[4:3]];
        3'h4:    rdata_o <= {5'h00, cfg_ff[addr_i[4:3]]};
        3'h5:    rdata_o <= {3'h0, ecode_ff[addr_i[4:3]]};
        3'h6:    rdata_o <= mcnt_ff[addr_i[4:3]][7:0];
        default: rdata_o <= bcnt_ff[addr_i[4:3]][7:0];
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

endmodule

// ===== dmacs_ctl_props.sv
`timescale 1ns/1ps
module dmacs_ctl_props #(
  parameter int NCH = 4,
  parameter int CW  = 16
) (
  input wire logic           clk_i,
  input wire logic           reset_n_i,
  input wire logic [4:0]     addr_i,
  input wire logic [7:0]     wdata_i,
  input wire logic           wr_i,
  input wire logic           rd_i,
  input wire logic [7:0]     rdata_o,
  input wire logic [NCH-1:0] operand_done_i,
  input wire logic [NCH-1:0] peripheral_control_line_i,
  input wire logic           interrupt_acknowledge_input_i,
  input wire logic [NCH-1:0] xfer_enable_o,
  input wire logic [NCH-1:0] done_o,
  input wire logic [NCH-1:0] irq_o,
  input wire logic           irq_any_o,
  input wire logic [7:0]     vector_o,
  input wire logic           transfer_acknowledge_o
);
  logic pcl0;
  logic ctl0_wr;

  // Channel 0 line and control write decode
  assign pcl0    = peripheral_control_line_i[0];
  assign ctl0_wr = wr_i && addr_i == 5'h00;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);

  // ---------------------------------------------------------------
  // Channel 0 completion, abort and status
  // ---------------------------------------------------------------
  a_done_one_cycle: assert property (done_o[0] |=> !done_o[0])
    else $error("done pulse too long");
  a_done_after_operand: assert property (done_o[0] |-> $past(operand_done_i[0], 2))
    else $error("done without final operand");
  a_abort_stops_xfer: assert property (ctl0_wr && wdata_i[dmacs_pkg::CTL_ABORT] |-> ##[1:3] !xfer_enable_o[0])
    else $error("abort left channel enabled");
  a_abort_reads_zero: assert property (rd_i && addr_i[2:0] == 3'h0 |=> !rdata_o[dmacs_pkg::CTL_ABORT])
    else $error("abort bit read as one");
  a_level_bit_tracks: assert property (rd_i && addr_i == 5'h01 && $past(pcl0) == pcl0 && $past(pcl0, 2) == pcl0
    |=> rdata_o[dmacs_pkg::STS_PCS] == $past(pcl0)) else $error("level bit differs from line");
  // ---------------------------------------------------------------
  // Interrupt request and vector cycle
  // ---------------------------------------------------------------
  a_ie_off_drops_irq: assert property (ctl0_wr && !wdata_i[dmacs_pkg::CTL_IE] |-> ##[1:3] !irq_o[0])
    else $error("irq kept with enable clear");
  a_irq_any_cause: assert property (irq_any_o |-> (|irq_o) || (|$past(irq_o)))
    else $error("irq_any without channel irq");
  a_ack_follows_req: assert property (transfer_acknowledge_o |-> $past(interrupt_acknowledge_input_i))
    else $error("vector ack without acknowledge");
  a_ack_needs_irq: assert property ($rose(transfer_acknowledge_o) |-> irq_o != '0)
    else $error("vector ack without request");
  a_vector_idle: assert property (!transfer_acknowledge_o |-> vector_o == 8'h00)
    else $error("vector driven while idle");

  c_done: cover property (done_o[0]);
  c_vector: cover property (transfer_acknowledge_o);
  c_irq_pair: cover property (irq_o[0] && irq_o[1]);
endmodule

bind dmacs_ctl dmacs_ctl_props #(.NCH(NCH), .CW(CW)) u_props (
  .clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .operand_done_i(operand_done_i), .peripheral_control_line_i(peripheral_control_line_i),
  .interrupt_acknowledge_input_i(interrupt_acknowledge_input_i), .xfer_enable_o(xfer_enable_o),
  .done_o(done_o), .irq_o(irq_o), .irq_any_o(irq_any_o), .vector_o(vector_o),
  .transfer_acknowledge_o(transfer_acknowledge_o));

// ===== dmacs_periph.sv
`timescale 1ns/1ps
module dmacs_periph (
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  input  wire logic [3:0] xfer_enable_i,
  input  wire logic       slow_i,
  input  wire logic [3:0] term_i,
  output logic [3:0]      req_o,
  output logic [3:0]      ack_o,
  output logic [3:0]      operand_done_o,
  output logic [3:0]      done_o
);
  logic [2:0] gap_ff;
  logic       fire;

  // Request always asserted on every channel; this device always has data
  assign req_o = 4'hf;
  assign fire  = (gap_ff == (slow_i ? 3'h6 : 3'h2));

  // One operand per enabled channel each gap; done only while acknowledged
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      gap_ff         <= 3'h0;
      ack_o          <= 4'h0;
      operand_done_o <= 4'h0;
      done_o         <= 4'h0;
    end else begin
      gap_ff         <= fire ? 3'h0 : gap_ff + 3'h1;
      ack_o          <= fire ? xfer_enable_i : 4'h0;
      operand_done_o <= fire ? xfer_enable_i : 4'h0;
      done_o         <= fire ? (xfer_enable_i & term_i) : 4'h0;
    end
  end
endmodule

// ===== test_dma_channel_control_status.sv
`timescale 1ns/1ps
module test_dma_channel_control_status;
  logic       clk_i        = 1'b0;
  logic       reset_n_i    = 1'b0;
  logic [4:0] addr_i       = 5'h00;
  logic [7:0] wdata_i      = 8'h00;
  logic       wr_i         = 1'b0;
  logic       rd_i         = 1'b0;
  logic       int_ack      = 1'b0;
  logic       slow         = 1'b0;
  logic [3:0] term         = 4'h0;
  logic [3:0] berr         = 4'h0;
  logic [3:0] peripheral_control_line          = 4'hf;
  logic [3:0] req, opd, ack, pdone, pend, xen, done, irq;
  logic [7:0] rdata, vec;
  logic       irq_any, tack;
  int         failures     = 0;
  int         total_checks = 0;
  logic [7:0] e_cfg [4]    = '{8'h01, 8'h03, 8'h00, 8'h00};
  logic [7:0] e_cnt [4]    = '{8'h02, 8'h02, 8'h00, 8'h02};
  logic [7:0] e_ctl [4]    = '{8'h80, 8'hc0, 8'h80, 8'h40};
  logic [7:0] e_code [4]   = '{8'h01, 8'h01, 8'h0d, 8'h02};

  initial forever #12.5 clk_i = ~clk_i;

  dmacs_ctl #(.NCH(4), .CW(16)) i_dut (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata), .req_i(req), .operand_done_i(opd), .bus_error_i(berr), .ack_i(ack), .done_i(pdone),
    .peripheral_control_line_i(peripheral_control_line), .interrupt_acknowledge_input_i(int_ack), .pending_req_o(pend),
    .xfer_enable_o(xen), .done_o(done), .irq_o(irq), .irq_any_o(irq_any), .vector_o(vec),
    .transfer_acknowledge_o(tack));
  dmacs_periph i_periph (.clk_i(clk_i), .reset_n_i(reset_n_i), .xfer_enable_i(xen), .slow_i(slow),
    .term_i(term), .req_o(req), .ack_o(ack), .operand_done_o(opd), .done_o(pdone));

  // ---------------------------------------------------------------
  // Bus access and compare tasks
  // ---------------------------------------------------------------
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input int ch, input int idx, input logic [7:0] d);
    @(posedge clk_i);
    {wr_i, addr_i, wdata_i} <= {1'b1, ch[1:0], idx[2:0], d};
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rchk(input int ch, input int idx, input logic [7:0] exp, input string name,
                      input logic [7:0] mask = 8'hff);
    @(posedge clk_i);
    {rd_i, addr_i} <= {1'b1, ch[1:0], idx[2:0]};
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk(name, exp, rdata & mask);
  endtask
  task automatic start(input int ch, input logic [7:0] cfg, input logic [7:0] cnt, input logic [7:0] ctl);
    wr(ch, 4, cfg);
    wr(ch, 6, cnt);
    wr(ch, 0, ctl);
  endtask
  task automatic wait_done(input int ch);
    for (int n = 0; n < 300 && done[ch] !== 1'b1; n++) @(posedge clk_i) #1;
    chk("done", 8'h01, {7'h00, done[ch]});
  endtask
  task automatic ivec(input logic [7:0] exp);
    @(posedge clk_i);
    int_ack <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1 chk("vector", exp, vec);
    chk("vector ack", 8'h01, {7'h00, tack});
    @(posedge clk_i);
    int_ack <= 1'b0;
  endtask
  task automatic finish_test;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    finish_test;
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk_i);
    reset_n_i <= 1'b1;
    rchk(0, 2, 8'h0f, "nvec reset");
    rchk(3, 3, 8'h0f, "evec reset");
    wr(0, 2, 8'h40);
    wr(1, 3, 8'h51);
    // Normal run on channel 0, count error on channel 1, vectors by priority
    start(0, 8'h00, 8'h02, 8'h88);
    rchk(0, 1, 8'h09, "active");
    wait_done(0);
    rchk(0, 1, 8'h81, "complete");
    start(1, 8'h00, 8'h00, 8'h88);
    rchk(1, 1, 8'h91, "count error");
    chk("irq", 8'h03, {4'h0, irq});
    ivec(8'h40);
    wr(0, 1, 8'hff);
    ivec(8'h51);
    wr(1, 1, 8'hff);
    rchk(1, 1, 8'h01, "cleared");
    chk("irq off", 8'h00, {3'h0, irq_any, irq});
    // Refused starts and a continue without start, each followed by a start while flags are set
    for (int i = 0; i < 4; i++) begin
      start(2, e_cfg[i], e_cnt[i], e_ctl[i]);
      rchk(2, 1, 8'h91, "refused");
      rchk(2, 5, e_code[i], "code");
      wr(2, 0, 8'h80);
      rchk(2, 5, 8'h02, "timing code");
      wr(2, 1, 8'hff);
    end
    // Two blocks in continue mode with a slow peripheral
    wr(3, 7, 8'h01);
    slow <= 1'b1;
    start(3, 8'h00, 8'h01, 8'hc0);
    wait_done(3);
    rchk(3, 1, 8'h49, "block");
    wait_done(3);
    rchk(3, 1, 8'hc1, "last block");
    wr(3, 1, 8'hff);
    slow <= 1'b0;
    // Halted channel keeps its request, active ignores status writes
    start(0, 8'h00, 8'h02, 8'ha0);
    repeat (20) @(posedge clk_i);
    wr(0, 1, 8'hff);
    rchk(0, 1, 8'h09, "halted");
    chk("pending", 8'h01, {7'h00, pend[0]});
    wr(0, 0, 8'h00);
    wait_done(0);
    wr(0, 1, 8'hff);
    // Software abort, then partial clear of the flags
    start(0, 8'h00, 8'h03, 8'ha0);
    wr(0, 0, 8'h10);
    rchk(0, 1, 8'h91, "abort");
    rchk(0, 5, 8'h11, "abort code");
    wr(0, 1, 8'h10);
    rchk(0, 1, 8'h81, "partial clear");
    rchk(0, 0, 8'h00, "control read");
    wr(0, 1, 8'hff);
    // Bus error on channel 1, peripheral termination on channel 2
    start(1, 8'h00, 8'h08, 8'h80);
    berr <= 4'h2;
    term <= 4'h4;
    repeat (8) @(posedge clk_i);
    berr <= 4'h0;
    rchk(1, 1, 8'h91, "bus error");
    rchk(1, 5, 8'h09, "bus code");
    start(2, 8'h00, 8'h04, 8'h80);
    repeat (10) @(posedge clk_i);
    rchk(2, 1, 8'h20, "termination", 8'h20);
    // Peripheral line: one-cycle glitch, then held low as interrupt input
    wr(0, 4, 8'h04);
    wr(0, 0, 8'h08);
    peripheral_control_line <= 4'he;
    @(posedge clk_i);
    peripheral_control_line <= 4'hf;
    repeat (4) @(posedge clk_i);
    rchk(0, 1, 8'h01, "glitch");
    @(posedge clk_i);
    peripheral_control_line <= 4'he;
    repeat (5) @(posedge clk_i);
    rchk(0, 1, 8'h02, "line low");
    chk("transition irq", 8'h01, {7'h00, irq[0]});
    finish_test;
  end
endmodule
